// *** shared/arc_pkg.sv ***
//------------------------------------------------------------
// audio routing crossbar constants
//------------------------------------------------------------
// Behaviour
// - eight destinations indexed 0 to 7
// - source 0 mutes the destination
// - sources 1,3 give channel averages
// - sources 2,4 give half differences
// - direct sources encoded 5 to 12
// - sources 13-15 pack pipeline, mic, reference
// - source 16 also set on partner channel
// - sources 17,18 pack inputs, host/serial width
// - 16 kHz mic samples repeated three times
// - signed shift gain per destination
// - left shift saturates on overflow
// - readback returns source and shift
// - documented default routing, no shift
// - six 16 kHz channels in stereo stream
// - packed width host-width or 32 bits
// - packed slot order mic1,mic0,refL,refR,asr,comms
// - mic marker 1, others marker 0
package arc_pkg;

  localparam int unsigned SAMPLE_W      = 32;
  localparam int unsigned HOST_SAMPLE_W = 16;
  localparam int unsigned NUM_DEST      = 8;
  localparam int unsigned SEL_W         = 5;
  localparam int unsigned SHIFT_W       = 6;

  // register offsets (byte addresses)
  localparam logic [7:0] MAP_BASE_OFS = 8'h00; // 8 words, one per destination
  localparam logic [7:0] STATUS_OFS   = 8'h20;

  // map word fields
  localparam int unsigned SEL_LSB   = 0;
  localparam int unsigned SHIFT_LSB = 8;
  // status fields
  localparam int unsigned PHASE_LSB   = 0;
  localparam int unsigned BADSEL_BIT  = 8;

  // source encodings
  localparam logic [4:0] SRC_MUTE         = 5'h00;
  localparam logic [4:0] SRC_HOST_MEAN    = 5'h01;
  localparam logic [4:0] SRC_HOST_HDIFF   = 5'h02;
  localparam logic [4:0] SRC_SERIAL_MEAN  = 5'h03;
  localparam logic [4:0] SRC_SERIAL_HDIFF = 5'h04;
  localparam logic [4:0] SRC_PIPE_A       = 5'h05;
  localparam logic [4:0] SRC_PIPE_B       = 5'h06;
  localparam logic [4:0] SRC_HOST_A       = 5'h07;
  localparam logic [4:0] SRC_HOST_B       = 5'h08;
  localparam logic [4:0] SRC_SERIAL_A     = 5'h09;
  localparam logic [4:0] SRC_SERIAL_B     = 5'h0A;
  localparam logic [4:0] SRC_MIC_A        = 5'h0B;
  localparam logic [4:0] SRC_MIC_B        = 5'h0C;
  localparam logic [4:0] SRC_PACK_PIPE    = 5'h0D;
  localparam logic [4:0] SRC_PACK_MIC     = 5'h0E;
  localparam logic [4:0] SRC_PACK_REF     = 5'h0F;
  localparam logic [4:0] SRC_PACK_ALL     = 5'h10;
  localparam logic [4:0] SRC_PACK_IN_HOST = 5'h11;
  localparam logic [4:0] SRC_PACK_IN_SER  = 5'h12;

  // reset routing, indexed by destination
  localparam logic [4:0] DEF_SEL [NUM_DEST] = '{
    5'h05, 5'h06, 5'h05, 5'h09, 5'h07, 5'h08, 5'h0B, 5'h0C};
  localparam logic [5:0] DEF_SHIFT = 6'h00;

  // packing frame phases at 48 kHz
  localparam logic [1:0] PHASE_MIC  = 2'h0;
  localparam logic [1:0] PHASE_REF  = 2'h1;
  localparam logic [1:0] PHASE_PIPE = 2'h2;

endpackage

// *** verilog/arc_crossbar.sv ***
`timescale 1ns/100ps
`default_nettype none

module arc_crossbar (
  // clock and reset
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  // ahb-lite slave
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // 48 kHz sample strobe from local audio logic
  input  wire  logic        frame_tick,
  // source samples
  input  wire  logic [31:0] host_in_a,
  input  wire  logic [31:0] host_in_b,
  input  wire  logic [31:0] serial_in_a,
  input  wire  logic [31:0] serial_in_b,
  input  wire  logic [31:0] pipe_out_a,
  input  wire  logic [31:0] pipe_out_b,
  input  wire  logic [31:0] mic_raw_a,
  input  wire  logic [31:0] mic_raw_b,
  // destination samples
  output logic [31:0]       host_out_a,
  output logic [31:0]       host_out_b,
  output logic [31:0]       serial_out_a,
  output logic [31:0]       serial_out_b,
  output logic [31:0]       echo_ref_in_a,
  output logic [31:0]       echo_ref_in_b,
  output logic [31:0]       capture_in_a,
  output logic [31:0]       capture_in_b,
  output logic              out_valid
);

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  // power-of-two gain; left shifts clip instead of wrapping
  function automatic logic [31:0] gain(input logic [31:0] x, input logic [5:0] s);
    logic signed [63:0] wide;
    logic [5:0]         mag;
    wide = 64'($signed(x));
    mag  = 6'(-s);
    if (s[5]) begin
      gain = 32'($signed(x) >>> mag);
    end else begin
      wide = wide <<< s;
      if (wide > 64'sh000000007FFFFFFF) begin
        gain = 32'h7FFFFFFF;
      end else if (wide < -64'sh0000000080000000) begin
        gain = 32'h80000000;
      end else begin
        gain = wide[31:0];
      end
    end
  endfunction

  // sum or difference halved in 33 bits so nothing overflows
  function automatic logic [31:0] halve(input logic [31:0] a, input logic [31:0] b,
                                        input logic diff);
    logic signed [32:0] r;
    r = diff ? (33'($signed(a)) - 33'($signed(b))) : (33'($signed(a)) + 33'($signed(b)));
    halve = r[32:1];
  endfunction

  // marker in the lowest kept bit; narrow paths keep only the top bits
  function automatic logic [31:0] mark(input logic [31:0] x, input logic m,
                                       input logic narrow);
    logic [31:0] y;
    y = x;
    if (narrow) begin
      y[arc_pkg::SAMPLE_W-arc_pkg::HOST_SAMPLE_W-1:0] = '0;
      y[arc_pkg::SAMPLE_W-arc_pkg::HOST_SAMPLE_W] = m;
    end else begin
      y[0] = m;
    end
    mark = y;
  endfunction

  //------------------------------------------------------------
  // register state
  //------------------------------------------------------------
  logic [4:0]  sel      [arc_pkg::NUM_DEST];
  logic [5:0]  shift    [arc_pkg::NUM_DEST];
  logic [4:0]  next_sel [arc_pkg::NUM_DEST];
  logic [5:0]  next_shift [arc_pkg::NUM_DEST];
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        bad_sel;
  logic        next_bad_sel;
  logic [1:0]  phase;
  logic [31:0] dest_q   [arc_pkg::NUM_DEST];
  logic [31:0] mic_hold [2];
  logic [31:0] ref_hold [2];
  logic [31:0] pipe_hold [2];
  logic        addr_ok;
  logic [31:0] next_rdata;
  logic [2:0]  wr_dest;
  logic [4:0]  wr_sel;

  assign addr_ok = hsel & htrans[1] & hready;
  assign wr_dest = wr_addr[4:2];
  assign wr_sel  = hwdata[arc_pkg::SEL_LSB +: arc_pkg::SEL_W];

  // address phase capture; writes land in the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // next map: data phase write, pairing of the all-channel packer
  always_comb begin
    next_bad_sel = bad_sel;
    for (int d = 0; d < arc_pkg::NUM_DEST; d++) begin
      next_sel[d]   = sel[d];
      next_shift[d] = shift[d];
    end
    if (wr_pend && wr_addr[7:5] == arc_pkg::MAP_BASE_OFS[7:5]
        && wr_addr[1:0] == 2'h0) begin
      next_shift[wr_dest] = hwdata[arc_pkg::SHIFT_LSB +: arc_pkg::SHIFT_W];
      // out-of-range selections leave the old source in place
      if (wr_sel > arc_pkg::SRC_PACK_IN_SER) begin
        next_bad_sel = 1'b1;
      end else begin
        next_sel[wr_dest] = wr_sel;
        if (wr_sel == arc_pkg::SRC_PACK_ALL) begin
          next_sel[wr_dest ^ 3'h1] = arc_pkg::SRC_PACK_ALL;
        end
      end
    end else if (wr_pend && wr_addr == arc_pkg::STATUS_OFS && hwdata[arc_pkg::BADSEL_BIT]) begin
      next_bad_sel = 1'b0;
    end
  end

  // routing map storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int d = 0; d < arc_pkg::NUM_DEST; d++) begin
        sel[d]   <= arc_pkg::DEF_SEL[d];
        shift[d] <= arc_pkg::DEF_SHIFT;
      end
      bad_sel <= 1'b0;
    end else begin
      for (int d = 0; d < arc_pkg::NUM_DEST; d++) begin
        sel[d]   <= next_sel[d];
        shift[d] <= next_shift[d];
      end
      bad_sel <= next_bad_sel;
    end
  end

  // read mux uses next map so a read right after a write sees it
  always_comb begin
    next_rdata = 32'h00000000;
    if (haddr[7:5] == arc_pkg::MAP_BASE_OFS[7:5] && haddr[31:8] == 24'h000000) begin
      next_rdata[arc_pkg::SEL_LSB +: arc_pkg::SEL_W]     = next_sel[haddr[4:2]];
      next_rdata[arc_pkg::SHIFT_LSB +: arc_pkg::SHIFT_W] = next_shift[haddr[4:2]];
    end else if (haddr[31:0] == {24'h000000, arc_pkg::STATUS_OFS}) begin
      next_rdata[arc_pkg::PHASE_LSB +: 2] = phase;
      next_rdata[arc_pkg::BADSEL_BIT]     = next_bad_sel;
    end
  end

  // bus answer: zero wait, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  //------------------------------------------------------------
  // sample path
  //------------------------------------------------------------
  // frame phase and 16 kHz holds; a hold lasts three 48 kHz ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= arc_pkg::PHASE_MIC;
      for (int c = 0; c < 2; c++) begin
        mic_hold[c]  <= 32'h00000000;
        ref_hold[c]  <= 32'h00000000;
        pipe_hold[c] <= 32'h00000000;
      end
    end else if (frame_tick) begin
      phase <= (phase == arc_pkg::PHASE_PIPE) ? arc_pkg::PHASE_MIC : 2'(phase + 2'h1);
      if (phase == arc_pkg::PHASE_PIPE) begin
        mic_hold[0]  <= mic_raw_a;
        mic_hold[1]  <= mic_raw_b;
        ref_hold[0]  <= dest_q[4];
        ref_hold[1]  <= dest_q[5];
        pipe_hold[0] <= pipe_out_a;
        pipe_hold[1] <= pipe_out_b;
      end
    end
  end

  // per-destination source select and gain
  logic [31:0] next_dest [arc_pkg::NUM_DEST];
  always_comb begin
    logic [31:0] v;
    logic        odd;
    logic        narrow;
    v      = 32'h00000000;
    odd    = 1'b0;
    narrow = 1'b0;
    for (int d = 0; d < arc_pkg::NUM_DEST; d++) begin
      odd    = d[0];
      // host-width packing for 17 anywhere, for 16 on the host pair only
      narrow = 1'b0;
      if (sel[d] == arc_pkg::SRC_PACK_IN_HOST) begin
        narrow = 1'b1;
      end else if (sel[d] == arc_pkg::SRC_PACK_ALL && d < 2) begin
        narrow = 1'b1;
      end
      case (sel[d])
        arc_pkg::SRC_MUTE:         v = 32'h00000000;
        arc_pkg::SRC_HOST_MEAN:    v = halve(host_in_a, host_in_b, 1'b0);
        arc_pkg::SRC_HOST_HDIFF:   v = halve(host_in_a, host_in_b, 1'b1);
        arc_pkg::SRC_SERIAL_MEAN:  v = halve(serial_in_a, serial_in_b, 1'b0);
        arc_pkg::SRC_SERIAL_HDIFF: v = halve(serial_in_a, serial_in_b, 1'b1);
        arc_pkg::SRC_PIPE_A:       v = pipe_out_a;
        arc_pkg::SRC_PIPE_B:       v = pipe_out_b;
        arc_pkg::SRC_HOST_A:       v = host_in_a;
        arc_pkg::SRC_HOST_B:       v = host_in_b;
        arc_pkg::SRC_SERIAL_A:     v = serial_in_a;
        arc_pkg::SRC_SERIAL_B:     v = serial_in_b;
        arc_pkg::SRC_MIC_A:        v = mic_hold[0];
        arc_pkg::SRC_MIC_B:        v = mic_hold[1];
        arc_pkg::SRC_PACK_PIPE:    v = pipe_hold[odd];
        arc_pkg::SRC_PACK_MIC:     v = mic_hold[odd];
        arc_pkg::SRC_PACK_REF:     v = ref_hold[odd];
        default:                   v = 32'h00000000;
      endcase
      v = gain(v, shift[d]);
      // packed forms: gain before marker so the marker survives
      if (sel[d] >= arc_pkg::SRC_PACK_ALL) begin
        case (phase)
          arc_pkg::PHASE_MIC: v = mark(gain(mic_hold[!odd], shift[d]), 1'b1,
                                       narrow);
          arc_pkg::PHASE_REF: v = mark(gain(ref_hold[odd], shift[d]), 1'b0, narrow);
          default: begin
            // input variants leave the pipeline slots empty
            v = (sel[d] == arc_pkg::SRC_PACK_ALL) ? gain(pipe_hold[odd], shift[d])
                                                  : 32'h00000000;
            v = mark(v, 1'b0, narrow);
          end
        endcase
      end
      next_dest[d] = v;
    end
  end

  // destination registers update once per 48 kHz tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int d = 0; d < arc_pkg::NUM_DEST; d++) begin
        dest_q[d] <= 32'h00000000;
      end
      out_valid <= 1'b0;
    end else begin
      out_valid <= frame_tick;
      if (frame_tick) begin
        for (int d = 0; d < arc_pkg::NUM_DEST; d++) begin
          dest_q[d] <= next_dest[d];
        end
      end
    end
  end

  // destination order: host, serial, reference, microphone
  assign host_out_a    = dest_q[0];
  assign host_out_b    = dest_q[1];
  assign serial_out_a  = dest_q[2];
  assign serial_out_b  = dest_q[3];
  assign echo_ref_in_a = dest_q[4];
  assign echo_ref_in_b = dest_q[5];
  assign capture_in_a  = dest_q[6];
  assign capture_in_b  = dest_q[7];

endmodule

`default_nettype wire

// *** testbench/arc_crossbar_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// crossbar port checker, watches destination 2 in detail
// ------------------------------------------------------------
module arc_crossbar_assertions (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // audio
  input wire logic        frame_tick,
  input wire logic [31:0] serial_in_a,
  input wire logic [31:0] serial_in_b,
  input wire logic [31:0] serial_out_a,
  input wire logic [31:0] echo_ref_in_a,
  input wire logic [31:0] capture_in_a,
  input wire logic        out_valid
);
  logic        wr_ph;
  logic        wr_pb;
  logic [4:0]  sel_q;
  logic [5:0]  sh_q;
  logic [31:0] sa_q;
  logic [31:0] sb_q;
  logic [32:0] sum;
  logic [32:0] dif;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // shadow of the destination 2 map; a bad source keeps the old one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      wr_pb <= 1'b0;
      sel_q <= arc_pkg::DEF_SEL[2];
      sh_q  <= arc_pkg::DEF_SHIFT;
    end else if (hready) begin
      wr_ph <= hsel && htrans[1] && hwrite && haddr[7:0] == 8'h08;
      wr_pb <= hsel && htrans[1] && hwrite && haddr[7:0] == 8'h0C;
      if (wr_ph) begin
        sh_q <= hwdata[13:8];
        if (hwdata[4:0] <= 5'h12) begin
          sel_q <= hwdata[4:0];
        end
      end else if (wr_pb && hwdata[4:0] == 5'h10) begin
        // packer on destination 3 pulls destination 2 along
        sel_q <= 5'h10;
      end
    end
  end

  // serial inputs taken on the strobe, as the crossbar takes them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sa_q <= 32'h0;
      sb_q <= 32'h0;
    end else if (frame_tick) begin
      sa_q <= serial_in_a;
      sb_q <= serial_in_b;
    end
  end

  // 33 bits so neither mean nor half difference can overflow
  assign sum = {sa_q[31], sa_q} + {sb_q[31], sb_q};
  assign dif = {sa_q[31], sa_q} - {sb_q[31], sb_q};

  function automatic logic [31:0] gain(input logic [31:0] v, input logic [5:0] s);
    logic signed [63:0] w;
    w = {{32{v[31]}}, v};
    if (s[5]) w = w >>> (7'h40 - {1'b0, s});
    else w = w <<< s;
    if (w > 64'sh7FFFFFFF) return 32'h7FFFFFFF;
    if (w < -64'sh80000000) return 32'h80000000;
    return w[31:0];
  endfunction

  // a map write landing on the strobe edge is excluded by the stable terms
  property p_route(logic [4:0] s, logic [31:0] base);
    out_valid && $stable(sel_q) && $stable(sh_q) && sel_q == s
      |-> serial_out_a == gain(base, sh_q);
  endproperty

  AST_MUTE: assert property (p_route(5'h00, 32'h0))
    else $error("muted destination not zero");
  AST_MEAN: assert property (p_route(5'h03, sum[32:1]))
    else $error("serial mean wrong");
  AST_HDIFF: assert property (p_route(5'h04, dif[32:1]))
    else $error("serial half difference wrong");
  AST_DIRECT: assert property (p_route(5'h09, sa_q))
    else $error("direct serial sample or gain wrong");
  AST_SAT: assert property (out_valid && $stable(sel_q) && $stable(sh_q) && sel_q == 5'h09
    && !sh_q[5] && sh_q != 6'h00 && !sa_q[31] && (sa_q >> (6'h1F - sh_q)) != 32'h0
    |-> serial_out_a == 32'h7FFFFFFF) else $error("left shift did not saturate");
  AST_TICK_VALID: assert property (frame_tick |=> out_valid)
    else $error("no output strobe after tick");
  AST_VALID_CAUSE: assert property (out_valid |-> $past(frame_tick))
    else $error("output strobe without tick");
  AST_HOLD: assert property (!out_valid |-> $stable(serial_out_a)
    && $stable(echo_ref_in_a) && $stable(capture_in_a)) else $error("outputs moved off strobe");
  AST_READY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");

  cover property (out_valid && sel_q == arc_pkg::SRC_PACK_ALL);
  cover property (out_valid && sel_q == arc_pkg::SRC_SERIAL_MEAN);
  cover property (out_valid && sh_q == 6'h3C);
endmodule

bind arc_crossbar arc_crossbar_assertions i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .frame_tick, .serial_in_a, .serial_in_b,
  .serial_out_a, .echo_ref_in_a, .capture_in_a, .out_valid);
`default_nettype wire

// *** testbench/arc_audio_peer.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// audio peers: frame strobe and level samples
// ------------------------------------------------------------
module arc_audio_peer #(
  parameter int          PERIOD = 8,
  parameter logic [31:0] V [8]  = '{default: 32'h0}
) (
  // clock and reset
  input  wire logic   hclk,
  input  wire logic   hresetn,
  // strobe and samples
  output logic        frame_tick,
  output logic [31:0] smp [8]
);
  logic [7:0] cnt;

  // silent in reset so no strobe races the release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt        <= 8'h00;
      frame_tick <= 1'b0;
    end else begin
      cnt        <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
      frame_tick <= (cnt == 8'(PERIOD - 1));
    end
  end

  // samples are levels, held steady for the whole run
  assign smp = V;
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ------------------------------------------------------------
  // samples and routing rows for destination 2
  // ------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  s;
    logic [5:0]  h;
    logic [31:0] e;
  } arc_row_s;
  localparam logic [31:0] V [8] = '{32'h100, 32'h300, 32'h10000000, 32'hF0000002,
                                    32'h1000, 32'h2000, 32'h4000, 32'h8000};
  localparam arc_row_s ROWS [21] = '{
    '{5'h00, 6'h00, 32'h0}, '{5'h01, 6'h00, 32'h200}, '{5'h02, 6'h00, 32'hFFFFFF00},
    '{5'h03, 6'h00, 32'h1}, '{5'h04, 6'h00, 32'h0FFFFFFF}, '{5'h05, 6'h00, 32'h1000},
    '{5'h06, 6'h00, 32'h2000}, '{5'h07, 6'h00, 32'h100}, '{5'h08, 6'h00, 32'h300},
    '{5'h09, 6'h00, 32'h10000000}, '{5'h0A, 6'h00, 32'hF0000002}, '{5'h0B, 6'h00, 32'h4000},
    '{5'h0C, 6'h00, 32'h8000}, '{5'h0D, 6'h00, 32'h1000}, '{5'h0E, 6'h00, 32'h4000},
    '{5'h0F, 6'h00, 32'h100}, '{5'h07, 6'h04, 32'h1000}, '{5'h09, 6'h04, 32'h7FFFFFFF},
    '{5'h0A, 6'h04, 32'h80000000}, '{5'h08, 6'h3C, 32'h30}, '{5'h02, 6'h3C, 32'hFFFFFFF0}};

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, frame_tick, out_valid;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, hoa, hob, soa, sob, era, erb, cia, cib;
  logic [31:0] smp [8];
  int          fail_count, check_count, i, k;

  initial hclk = 1'b0;
  always #5 hclk = ~hclk;

  arc_crossbar i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frame_tick(frame_tick),
    .host_in_a(smp[0]), .host_in_b(smp[1]), .serial_in_a(smp[2]), .serial_in_b(smp[3]),
    .pipe_out_a(smp[4]), .pipe_out_b(smp[5]), .mic_raw_a(smp[6]), .mic_raw_b(smp[7]),
    .host_out_a(hoa), .host_out_b(hob), .serial_out_a(soa), .serial_out_b(sob),
    .echo_ref_in_a(era), .echo_ref_in_b(erb), .capture_in_a(cia), .capture_in_b(cib),
    .out_valid(out_valid));
  arc_audio_peer #(.PERIOD(8), .V(V)) i_peer (.hclk(hclk), .hresetn(hresetn),
    .frame_tick(frame_tick), .smp(smp));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // one single transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge hclk);
      while (out_valid !== 1'b1) @(posedge hclk);
    end
  endtask

  // finds the marked frame on the right channel, then walks one group of three
  task automatic pack(input logic hst, input logic [31:0] m1, input logic [31:0] m0,
                      input logic [31:0] rl, input logic [31:0] rr,
                      input logic [31:0] pa, input logic [31:0] pb);
    k = 0;
    ticks(1);
    while ((hst ? hob[0] : sob[0]) !== 1'b1 && k < 4) begin
      ticks(1);
      k++;
    end
    chk("slot0 mic1", m1, hst ? hoa : soa);
    chk("slot1 mic0", m0, hst ? hob : sob);
    ticks(1);
    chk("slot2 ref", rl, hst ? hoa : soa);
    chk("slot3 ref", rr, hst ? hob : sob);
    ticks(1);
    chk("slot4 pipe", pa, hst ? hoa : soa);
    chk("slot5 pipe", pb, hst ? hob : sob);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog, far beyond the thousand or so cycles the tests need
  initial begin
    #200000;
    fail_count++;
    print_verdict;
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    haddr = 32'h0; hwdata = 32'h0; fail_count = 0; check_count = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 21; i++) begin
      xfer(1'b1, 32'h08, {18'h0, ROWS[i].h, 3'h0, ROWS[i].s});
      xfer(1'b0, 32'h08, 32'h0);
      chk("map word", {18'h0, ROWS[i].h, 3'h0, ROWS[i].s}, rd);
      ticks(3);
      chk("routed sample", ROWS[i].e, soa);
    end
    // second reset in mid-run restores the default routing
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    chk("out in reset", 32'h0, soa);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 8; i++) begin
      xfer(1'b0, 32'(4 * i), 32'h0);
      chk("default map", {27'h0, arc_pkg::DEF_SEL[i]}, rd);
    end
    xfer(1'b0, 32'h40, 32'h0);
    chk("unmapped read", 32'h0, rd);
    ticks(3);
    chk("default host out", V[4], hoa);
    chk("default ref in", V[0], era);
    chk("default mic in", V[7], cib);
    chk("default host out b", V[5], hob);
    chk("default serial b", V[2], sob);
    chk("default ref in b", V[1], erb);
    chk("default mic in a", V[6], cia);
    xfer(1'b1, 32'h08, 32'h10);
    xfer(1'b0, 32'h0C, 32'h0);
    chk("partner channel", 32'h10, rd);
    pack(1'b0, V[7] | 32'h1, V[6] | 32'h1, V[0], V[1], V[4], V[5]);
    xfer(1'b1, 32'h08, 32'h12);
    xfer(1'b1, 32'h0C, 32'h12);
    pack(1'b0, V[7] | 32'h1, V[6] | 32'h1, V[0], V[1], 32'h0, 32'h0);
    // out-of-range source keeps the old one and raises the sticky flag
    xfer(1'b1, 32'h08, 32'h0000001F);
    xfer(1'b0, 32'h08, 32'h0);
    chk("bad source kept", 32'h00000012, rd);
    xfer(1'b0, 32'h20, 32'h0);
    chk("bad source flag", 32'h00000100, rd & 32'h00000100);
    xfer(1'b1, 32'h20, 32'h00000100);
    xfer(1'b0, 32'h20, 32'h0);
    chk("bad flag cleared", 32'h0, rd & 32'h00000100);
    // host-width input packing with gain on the left, full word on the right
    xfer(1'b1, 32'h00, 32'h00001011);
    xfer(1'b1, 32'h04, 32'h00000012);
    xfer(1'b0, 32'h00, 32'h0);
    chk("pack map", 32'h00001011, rd);
    pack(1'b1, 32'h7FFF0000, V[6] | 32'h1, 32'h01000000, V[1], 32'h0, 32'h0);
    print_verdict;
  end
endmodule
`default_nettype wire
